// File: logic/config_load_pkg.sv
// constants and carrier types for the configuration load sequencer
package config_load_pkg;
   // clock and timing
   localparam int unsigned REF_CLK_HZ       = 20_000_000;         // ref_clk rate
   localparam int unsigned RESET_PULSE_NS   = 320;                // least reconfiguration pulse
   localparam int unsigned RESET_PULSE_CYC  =
      (RESET_PULSE_NS * (REF_CLK_HZ / 1_000_000) + 999) / 1000;   // rounded up
   localparam int unsigned SETTLE_US        = 25;                 // least post-done settle
   localparam int unsigned SETTLE_CYC       = SETTLE_US * (REF_CLK_HZ / 1_000_000);
   localparam int unsigned FIRST_DATA_NS    = 1200;               // host wait before first data
   localparam int unsigned FIRST_DATA_CYC   =
      (FIRST_DATA_NS * (REF_CLK_HZ / 1_000_000) + 999) / 1000;
   // chain master extension: 1344 / data-line count loader clock periods
   localparam int unsigned CHAIN_BITS       = 1344;
   // passive clock ceilings in MHz, by bus width
   localparam int unsigned PASSIVE_X1_MHZ   = 25;
   localparam int unsigned PASSIVE_X8_MHZ   = 50;
   localparam int unsigned PASSIVE_X32_MHZ  = 100;
   // active divider: nominal loader clock rates in MHz
   localparam int unsigned QUARTER_RATE_MHZ = 20;
   localparam int unsigned EIGHTH_RATE_MHZ  = 10;
   localparam logic [2:0]  QUARTER_HALF     = 3'h1;               // half period minus one, quarter rate
   localparam logic [2:0]  EIGHTH_HALF      = 3'h3;               // half period minus one, eighth rate
   localparam int          CNT_W            = 16;                 // timer width
   localparam logic [15:0] WORD_COUNT_RST   = 16'h0000;
   localparam logic [15:0] TIMER_RST        = 16'h0000;
   // data width codes
   localparam logic [2:0]  WIDTH_X1  = 3'h0;
   localparam logic [2:0]  WIDTH_X2  = 3'h1;
   localparam logic [2:0]  WIDTH_X4  = 3'h2;
   localparam logic [2:0]  WIDTH_X8  = 3'h3;
   localparam logic [2:0]  WIDTH_X16 = 3'h4;
   localparam logic [2:0]  WIDTH_X32 = 3'h5;

   typedef enum logic [5:0] {
      ST_IDLE   = 6'h01,   // waiting for reconfiguration
      ST_RESET  = 6'h02,   // reconfiguration input held low
      ST_WAIT   = 6'h04,   // release to first data window
      ST_LOAD   = 6'h08,   // taking words
      ST_SETTLE = 6'h10,   // done high, settle interval running
      ST_USER   = 6'h20    // user mode
   } load_state_t;

   // static setup straps
   typedef struct packed {
      logic        active_mode;     // device drives the loader clock
      logic        eighth_rate;     // eighth_rate_select, else quarter_rate_select
      logic        parallel_chain;  // parallel daisy chain of x2 or x4
      logic        chain_master;    // master of a two-device serial chain
      logic        scan_mode;       // configuration by boundary scan
      logic [2:0]  width_code;      // data-line count
   } load_setup_t;
endpackage

// File: logic/clock_divider.sv
// loader clock divider for active mode
`timescale 1ns/1ns
`default_nettype none
module clock_divider (
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic       run,        // divider runs while high
   input  wire logic [2:0] half_count, // ref cycles per half period minus one
   output logic            clk_out,    // divided clock
   output logic            rise        // pulse on each rising edge of clk_out
);
   typedef struct packed {
      logic [2:0] cnt;
      logic       clk;
      logic       rise;
   } div_state_t;

   div_state_t st_reg;
   div_state_t st_next;

   // count half periods and toggle
   always_comb begin
      st_next      = st_reg;
      st_next.rise = 1'b0;
      if (!run) begin
         st_next.cnt = 3'h0;
         st_next.clk = 1'b0;       // park low outside loading
      end else if (st_reg.cnt >= half_count) begin
         st_next.cnt  = 3'h0;
         st_next.clk  = ~st_reg.clk;
         st_next.rise = ~st_reg.clk;
      end else begin
         st_next.cnt = st_reg.cnt + 3'h1;
      end
   end

   // register state
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign clk_out = st_reg.clk;
   assign rise    = st_reg.rise;
endmodule
`default_nettype wire

// File: logic/config_load_sequencer.sv
// configuration load sequencer: reset pulse, loading, done flag and settle timing
`timescale 1ns/1ns
`default_nettype none
module config_load_sequencer #(
   parameter int unsigned SETTLE_CYCLES = config_load_pkg::SETTLE_CYC
) (
   input  wire logic                        ref_clk,
   input  wire logic                        rstn,
   input  wire logic                        reconfig_n,      // pin, active-low reconfiguration
   input  wire config_load_pkg::load_setup_t setup,          // straps, caught at reset release
   input  wire logic [15:0]                 bitstream_words, // words in the bitstream
   input  wire logic                        data_valid,      // pin, host marks a word
   input  wire logic                        user_entry_instruction, // pin, from tap update-ir
   output logic                             loader_clock_line,   // active-mode loader clock
   output logic                             load_complete_flag,  // done flag
   output logic                             user_mode,           // device in user mode
   output logic                             system_reset_n,      // held low until settled
   output logic                             data_accept          // pulse per accepted word
);

   typedef struct packed {
      config_load_pkg::load_state_t state;
      config_load_pkg::load_setup_t setup;
      logic                         setup_taken;
      logic [15:0]                  timer;       // pulse, wait and settle timer
      logic [15:0]                  words;       // words accepted
      logic                         valid_prev;  // edge detect on synced strobe
      logic                         done;
      logic                         user;
      logic                         sys_rst_n;
      logic                         accept;
      // pin stages and the loader clock live in the one state record, so apart
      // from the divider instance the module is one register with one next-value process
      logic [2:0]                   sync1;       // first pin stage, read only by sync2
      logic [2:0]                   sync2;       // second pin stage
      logic                         clk_out;     // loader clock, re-registered
   } seq_state_t;

   seq_state_t st_reg;
   seq_state_t st_next;

   // synchronised pin levels; only the second stage is ever read by logic,
   // so a metastable first stage never reaches the state machine
   // order in both stages: reconfiguration, strobe, entry instruction
   logic rcfg_n_s;  // reconfiguration, active low
   logic valid_s;   // host word strobe
   logic entry_s;   // entry instruction level
   assign rcfg_n_s = st_reg.sync2[2];
   assign valid_s  = st_reg.sync2[1];
   assign entry_s  = st_reg.sync2[0];

   // divider control
   logic       div_run;
   logic [2:0] div_half;
   logic       div_clk;
   logic       div_rise;
   assign div_run = st_reg.setup.active_mode &&
                    (st_reg.state == config_load_pkg::ST_LOAD);
   // parallel chain overrides the eighth-rate choice
   assign div_half = (st_reg.setup.eighth_rate && !st_reg.setup.parallel_chain) ?
                     config_load_pkg::EIGHTH_HALF : config_load_pkg::QUARTER_HALF;

   clock_divider u_div (
      .ref_clk    (ref_clk),
      .rstn       (rstn),
      .run        (div_run),
      .half_count (div_half),
      .clk_out    (div_clk),
      .rise       (div_rise)
   );

   // chain master extension in loader clock periods, scaled to ref cycles
   function automatic logic [15:0] chain_extra(input config_load_pkg::load_setup_t s);
      logic [15:0] bits;
      logic [15:0] per;
      bits = 16'(config_load_pkg::CHAIN_BITS);
      case (s.width_code)
         config_load_pkg::WIDTH_X2:  bits = bits >> 1;
         config_load_pkg::WIDTH_X4:  bits = bits >> 2;
         config_load_pkg::WIDTH_X8:  bits = bits >> 3;
         config_load_pkg::WIDTH_X16: bits = bits >> 4;
         config_load_pkg::WIDTH_X32: bits = bits >> 5;
         default:                    bits = bits;
      endcase
      // one loader period is two half periods of the divider
      per = (s.eighth_rate && !s.parallel_chain) ? 16'h0008 : 16'h0004;
      chain_extra = s.chain_master ? 16'(bits * per) : 16'h0000;
      return chain_extra;
   endfunction

   // sequencing
   always_comb begin
      st_next            = st_reg;
      st_next.accept     = 1'b0;
      st_next.valid_prev = valid_s;
      // pin stages: the first takes the raw pins, the second only copies the
      // first, so nothing but the second stage ever feeds a decision
      st_next.sync1      = {reconfig_n, data_valid, user_entry_instruction};
      st_next.sync2      = st_reg.sync1;
      // loader clock is re-registered so the pin is driven from a flip-flop;
      // it lags the divider by one reference cycle, which the flash never sees
      st_next.clk_out    = div_clk;
      // straps are caught once, on the first clock after reset release
      if (!st_reg.setup_taken) begin
         st_next.setup       = setup;
         st_next.setup_taken = 1'b1;
      end
      case (st_reg.state)
         config_load_pkg::ST_IDLE: begin
            if (!rcfg_n_s) begin
               st_next.state = config_load_pkg::ST_RESET;
               st_next.timer = 16'h0001;
            end
         end
         config_load_pkg::ST_RESET: begin
            st_next.done      = 1'b0;
            st_next.user      = 1'b0;
            st_next.sys_rst_n = 1'b0;
            if (!rcfg_n_s) begin
               if (st_reg.timer < 16'(config_load_pkg::RESET_PULSE_CYC)) begin
                  st_next.timer = st_reg.timer + 16'h0001;
               end
            end else if (st_reg.timer >= 16'(config_load_pkg::RESET_PULSE_CYC)) begin
               // long enough: restart configuration
               st_next.state = config_load_pkg::ST_WAIT;
               st_next.timer = config_load_pkg::TIMER_RST;
               st_next.words = config_load_pkg::WORD_COUNT_RST;
            end else begin
               // glitch too short: go back to idle
               st_next.state = config_load_pkg::ST_IDLE;
            end
         end
         config_load_pkg::ST_WAIT: begin
            // passive data before the first-data wait is ignored, not counted
            if (st_reg.timer >= 16'(config_load_pkg::FIRST_DATA_CYC - 1)) begin
               st_next.state = config_load_pkg::ST_LOAD;
            end else begin
               st_next.timer = st_reg.timer + 16'h0001;
            end
         end
         config_load_pkg::ST_LOAD: begin
            // active: one word per loader clock rise; passive: per strobe edge
            if ((st_reg.setup.active_mode && div_rise) ||
                (!st_reg.setup.active_mode && valid_s && !st_reg.valid_prev)) begin
               st_next.accept = 1'b1;
               st_next.words  = st_reg.words + 16'h0001;
               if (st_reg.words + 16'h0001 >= bitstream_words) begin
                  st_next.done  = 1'b1;
                  st_next.state = config_load_pkg::ST_SETTLE;
                  st_next.timer = config_load_pkg::TIMER_RST;
               end
            end
         end
         config_load_pkg::ST_SETTLE: begin
            // scan loads hold the timer until the entry instruction lands
            if (st_reg.setup.scan_mode && !entry_s && st_reg.timer == 16'h0000) begin
               st_next.timer = 16'h0000;
            end else if (st_reg.timer >=
                         16'(SETTLE_CYCLES - 1) + chain_extra(st_reg.setup)) begin
               st_next.state     = config_load_pkg::ST_USER;
               st_next.user      = 1'b1;
               st_next.sys_rst_n = 1'b1;
            end else begin
               st_next.timer = st_reg.timer + 16'h0001;
            end
         end
         config_load_pkg::ST_USER: begin
            // user mode is a floor, not a promise of later start
            st_next.user = 1'b1;
         end
         default: begin
            st_next.state = config_load_pkg::ST_IDLE;
         end
      endcase
      // a reconfiguration pulse interrupts any state
      if (!rcfg_n_s && st_reg.state != config_load_pkg::ST_RESET &&
          st_reg.state != config_load_pkg::ST_IDLE) begin
         st_next.state = config_load_pkg::ST_RESET;
         st_next.timer = 16'h0001;
         st_next.done  = 1'b0;
         // user mode and the system reset follow done down in the same cycle,
         // so user mode is never shown without done
         st_next.user      = 1'b0;
         st_next.sys_rst_n = 1'b0;
      end
   end

   // register state
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg           <= '0;
         st_reg.state     <= config_load_pkg::ST_IDLE;
         st_reg.sys_rst_n <= 1'b0;
         // pin stages rest at the idle pin levels: reconfiguration high,
         // strobe and entry low, so the strobe edge detector sees no false
         // edge in the first cycles after reset
         st_reg.sync1     <= 3'h4;
         st_reg.sync2     <= 3'h4;
      end else begin
         st_reg <= st_next;
      end
   end

   // every output is a bit of the state register
   assign loader_clock_line  = st_reg.clk_out;
   assign load_complete_flag = st_reg.done;
   assign user_mode          = st_reg.user;
   assign system_reset_n     = st_reg.sys_rst_n;
   assign data_accept        = st_reg.accept;
endmodule
`default_nettype wire

// File: testbench/config_load_chk.sv
// assertions on load sequencing, bound to the sequencer
`timescale 1ns/1ns
`default_nettype none
module config_load_chk #(
   parameter int unsigned SETTLE_CYCLES = 20
) (
   input wire logic                         ref_clk,
   input wire logic                         rstn,
   input wire logic                         reconfig_n,
   input wire config_load_pkg::load_setup_t setup,
   input wire logic [15:0]                  bitstream_words,
   input wire logic                         data_valid,
   input wire logic                         user_entry_instruction,
   input wire logic                         loader_clock_line,
   input wire logic                         load_complete_flag,
   input wire logic                         user_mode,
   input wire logic                         system_reset_n,
   input wire logic                         data_accept
);
   logic [15:0] done_cnt;  // cycles with done high
   logic [15:0] entry_cnt; // cycles with done and entry both high
   logic        quarter;   // effective quarter rate in active mode
   logic        eighth;    // effective eighth rate in active mode
   // a parallel chain overrides the eighth-rate strap
   assign quarter = setup.active_mode && (!setup.eighth_rate || setup.parallel_chain);
   assign eighth  = setup.active_mode && setup.eighth_rate && !setup.parallel_chain;
   // counters clear while done is low, so a reload restarts them
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         done_cnt  <= 16'h0000;
         entry_cnt <= 16'h0000;
      end else begin
         done_cnt  <= load_complete_flag ? done_cnt + 16'h0001 : 16'h0000;
         entry_cnt <= (load_complete_flag && user_entry_instruction) ? entry_cnt + 16'h0001
                                                                     : 16'h0000;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   a_reload_clears_done: assert property (!reconfig_n [*8] |-> !load_complete_flag)
      else $error("done high during a long reconfiguration pulse");
   a_done_holds_high: assert property (load_complete_flag && reconfig_n && $past(reconfig_n)
      && $past(reconfig_n, 2) |=> load_complete_flag) else $error("done dropped without reload");
   a_settle_before_user: assert property ($rose(user_mode) |-> done_cnt >= SETTLE_CYCLES)
      else $error("user mode entered before the settle interval");
   a_user_needs_done: assert property (user_mode |-> load_complete_flag)
      else $error("user mode without done");
   a_sysrst_after_settle: assert property ($rose(system_reset_n) |-> user_mode
      && done_cnt >= SETTLE_CYCLES) else $error("system reset released early");
   a_scan_waits_entry: assert property ($rose(user_mode) && setup.scan_mode
      |-> entry_cnt >= SETTLE_CYCLES) else $error("scan settle began before entry");
   a_accept_one_cycle: assert property (data_accept |=> !data_accept)
      else $error("word accept longer than one cycle");
   a_done_last_word: assert property ($rose(load_complete_flag) |-> data_accept)
      else $error("done rose without a word");
   a_quarter_period: assert property ($rose(loader_clock_line) && quarter
      |=> (!$rose(loader_clock_line)) [*3]) else $error("quarter clock too fast");
   a_eighth_period: assert property ($rose(loader_clock_line) && eighth
      |=> (!$rose(loader_clock_line)) [*7]) else $error("eighth clock too fast");
   a_passive_clock_quiet: assert property (!setup.active_mode |-> !loader_clock_line)
      else $error("loader clock running in passive mode");
   c_user: cover property ($rose(user_mode));
   c_eighth: cover property ($rose(loader_clock_line) && eighth);
   c_scan: cover property ($rose(user_mode) && setup.scan_mode);
   c_chain: cover property ($rose(user_mode) && setup.chain_master);
endmodule
bind config_load_sequencer config_load_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) config_load_chk_i (
   .ref_clk(ref_clk), .rstn(rstn), .reconfig_n(reconfig_n), .setup(setup),
   .bitstream_words(bitstream_words), .data_valid(data_valid),
   .user_entry_instruction(user_entry_instruction), .loader_clock_line(loader_clock_line),
   .load_complete_flag(load_complete_flag), .user_mode(user_mode),
   .system_reset_n(system_reset_n), .data_accept(data_accept));
`default_nettype wire

// File: testbench/config_host_model.sv
// passive host model: strobes configuration words after each reconfiguration
`timescale 1ns/1ns
`default_nettype none
module config_host_model (
   input  wire logic        ref_clk,
   input  wire logic        reconfig_n, // reconfiguration pin, driven by the bench
   input  wire logic        passive,    // strobes only in passive mode
   input  wire logic [15:0] n_words,    // words per load
   input  wire logic [3:0]  gap,        // low cycles between strobes, at least one
   output logic             data_valid  // word strobe
);
   int   n;               // words sent so far
   logic rel_prev = 1'b1; // pin level at the previous edge
   initial data_valid = 1'b0;
   // a load begins at pin release, seen on the reference clock so that the
   // pin's first value at time zero is never taken for a release; the margin
   // covers the input synchroniser
   always @(posedge ref_clk) begin
      rel_prev <= reconfig_n;
      if (passive && reconfig_n && !rel_prev) begin
         repeat (config_load_pkg::FIRST_DATA_CYC + 6) @(posedge ref_clk);
         for (n = 0; n < n_words; n++) begin
            data_valid <= 1'b1; // one cycle high keeps the rate far below the ceiling
            @(posedge ref_clk);
            data_valid <= 1'b0;
            repeat (gap) @(posedge ref_clk);
         end
      end
   end
endmodule
`default_nettype wire

// File: testbench/config_load_sequencer_test.sv
// self-checking bench for the configuration load sequencer
`timescale 1ns/1ns
`default_nettype none
module config_load_sequencer_test;
   localparam int unsigned SETTLE = 20; // shortened settle keeps the run short
   logic ref_clk, rstn, reconfig_n, data_valid, entry, lcl, done, user, sys_n, accept;
   config_load_pkg::load_setup_t setup; // straps, changed only in reset
   logic [15:0] words;                  // bitstream length
   logic [3:0]  gap;                    // host pause between strobes
   logic        lcl_d  = 1'b0;          // loader clock at the previous falling edge
   logic        done_d = 1'b0;          // done at the previous falling edge
   logic        user_d = 1'b0;          // user mode at the previous falling edge
   int failures, n_tests, cyc, acc, per, last_rise, t_done, t_user;
   config_load_sequencer #(.SETTLE_CYCLES(SETTLE)) config_load_sequencer_i (
      .ref_clk(ref_clk), .rstn(rstn), .reconfig_n(reconfig_n), .setup(setup),
      .bitstream_words(words), .data_valid(data_valid), .user_entry_instruction(entry),
      .loader_clock_line(lcl), .load_complete_flag(done), .user_mode(user),
      .system_reset_n(sys_n), .data_accept(accept));
   config_host_model config_host_model_i (.ref_clk(ref_clk), .reconfig_n(reconfig_n),
      .passive(!setup.active_mode), .n_words(words), .gap(gap), .data_valid(data_valid));
   always #25 ref_clk = ~ref_clk;
   // monitor on the falling edge, where outputs have settled
   always @(negedge ref_clk) begin
      cyc++;
      if (accept === 1'b1) acc++;
      if (lcl === 1'b1 && lcl_d === 1'b0) begin
         per = cyc - last_rise;
         last_rise = cyc;
      end
      if (done === 1'b1 && done_d === 1'b0) t_done = cyc;
      if (user === 1'b1 && user_d === 1'b0) t_user = cyc;
      lcl_d  = lcl;
      done_d = done;
      user_d = user;
      if (cyc == 60000) begin
         failures++;
         report_and_stop();
      end
   end
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %0h seen %0h", name, exp, got);
      end
   endtask
   // long pulse on the pin, then wait for done under a bound
   task automatic reload();
      int k;
      @(posedge ref_clk);
      reconfig_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      chk("done during reload", 0, done);
      acc = 0;
      reconfig_n <= 1'b1;
      for (k = 0; k < 4000 && done !== 1'b1; k++) @(negedge ref_clk);
      @(negedge ref_clk);
      chk("words accepted", words, acc);
   endtask
   task automatic load(input config_load_pkg::load_setup_t s, input logic [15:0] w);
      @(posedge ref_clk);
      setup <= s;
      words <= w;
      rstn <= 1'b0;
      repeat (10) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      reload();
   endtask
   task automatic wait_user(input int need);
      int k;
      for (k = 0; k < 3000 && user !== 1'b1; k++) @(negedge ref_clk);
      @(negedge ref_clk);
      chk("user mode", 1, user);
      chk("settle long enough", 1, (t_user - t_done) >= need);
      chk("system reset released", 1, sys_n);
   endtask
   task automatic t_passive();
      load('{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, config_load_pkg::WIDTH_X1}, 16'h0003);
      wait_user(SETTLE);
      gap <= 4'h3;
      reload();
      wait_user(SETTLE);
   endtask
   // quarter, eighth, and a parallel chain that must fall back to quarter
   task automatic t_active_rates();
      config_load_pkg::load_setup_t s;
      int i;
      for (i = 0; i < 3; i++) begin
         s = '{1'b1, i > 0, i == 2, 1'b0, 1'b0, config_load_pkg::WIDTH_X2};
         load(s, 16'h0005);
         chk("loader clock period", (i == 1) ? 8 : 4, per);
         wait_user(SETTLE);
      end
   endtask
   task automatic t_chain();
      load('{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, config_load_pkg::WIDTH_X8}, 16'h0004);
      wait_user(SETTLE + (1344 / 8) * 4);
   endtask
   task automatic t_scan();
      load('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, config_load_pkg::WIDTH_X1}, 16'h0002);
      repeat (40) @(negedge ref_clk);
      chk("user mode before entry", 0, user);
      @(posedge ref_clk);
      entry <= 1'b1;
      t_done = cyc;
      wait_user(SETTLE);
      @(posedge ref_clk);
      entry <= 1'b0;
   endtask
   task report_and_stop();
      $display("Checks %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      rstn = 1'b0;
      reconfig_n = 1'b1;
      entry = 1'b0;
      setup = '0;
      words = 16'h0000;
      gap = 4'h1;
      repeat (10) @(posedge ref_clk);
      t_passive();
      t_active_rates();
      t_chain();
      t_scan();
      report_and_stop();
   end
endmodule
`default_nettype wire
